/* File: chbd_host.sv */
// Host controller that powers, mode-selects and drives a removable card over its bus pins
// Contract
// - Byte read: low enable, lane0, A0 picks
// - Byte write: low lane only, A0 picks
// - Both enables low: word, A0 ignored
// - High enable only: odd byte, upper lane
// - Output strobe grounded at power-up: direct mode
// - Host relies only on grounded power-up method
// - Host ignores drive address bit 7
// - Primary mapping normally uses interrupt 14
`timescale 1ns/10ps
`include "chbd_cfg.svh"
module chbd_host
    import chbd_pkg::*;
#(
    parameter int PWRUP_CYC = `CHBD_PWRUP_CYC
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic [10:0] CARD_ADDR,
    output logic ATTR_SELECT_N,
    output logic LOW_BYTE_ENABLE_N,
    output logic HIGH_BYTE_ENABLE_N,
    output logic INTERFACE_SELECT_N,
    output logic WRITE_STROBE_N,
    output logic IO_READ_STROBE_N,
    output logic IO_WRITE_STROBE_N,
    output logic COMMAND_BLOCK_SELECT_N,
    output logic CONTROL_BLOCK_SELECT_N,
    output logic TRANSFER_ACKNOWLEDGE_N,
    output logic CARD_RESET,
    output logic CARD_POWER,
    output logic [15:0] DATA_OUT,
    output logic [1:0] DATA_OE_N,
    input wire logic [15:0] DATA_IN,
    input wire logic WAIT_N,
    input wire logic READY,
    input wire logic CARD_DETECT_N
);
    typedef enum logic [1:0] {P_OFF, P_UP, P_RST, P_ON} chbd_pwr_t;
    typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} chbd_cyc_t;

    chbd_pwr_t pwr_q;
    chbd_cyc_t cyc_q;
    logic [5:0] ctrl_q;
    logic [10:0] addr_q;
    logic [15:0] wdata_q;
    logic [15:0] rdata_q;
    logic err_q;
    logic direct_q;
    logic rst_done_q;
    logic [16:0] pcnt_q;
    logic [4:0] ccnt_q;
    chbd_width_t cw_q;
    logic cwr_q;
    logic cio_q;
    logic ca0_q;
    logic [15:0] cwd_q;
    logic drv_q;
    logic [3:0] toff;

    chbd_lane_if lif();
    chbd_lane u_lane (.lif(lif));

    assign lif.width = cw_q;
    assign lif.wr = cwr_q;
    assign lif.a0 = ca0_q;
    assign lif.wdata = cwd_q;
    assign lif.din = DATA_IN;

    // Pin address of a task file register for the selected mapping
    function automatic logic [10:0] map_addr(input logic [1:0] idx, input logic [3:0] off);
        logic ctl;
        ctl = (off == `CHBD_TF_ALTSTAT) || (off == `CHBD_TF_DRVADDR);
        unique case (idx)
            2'd0: map_addr = {7'h00, off};
            2'd1: map_addr = {7'h00, off};
            2'd2: map_addr = ctl ? (`CHBD_PRI_CTL | {8'h00, off[2:0]}) : (`CHBD_PRI_CMD | {8'h00, off[2:0]});
            2'd3: map_addr = ctl ? (`CHBD_SEC_CTL | {8'h00, off[2:0]}) : (`CHBD_SEC_CMD | {8'h00, off[2:0]});
        endcase
    endfunction

    wire cmd_wr = WR && (ADDR == `CHBD_OFF_CMD);
    wire chbd_space_t sp = chbd_space_t'(WDATA[`CHBD_CMD_SPACE_LO +: 2]);
    wire chbd_width_t wd = chbd_width_t'(WDATA[`CHBD_CMD_WIDTH_LO +: 2]);
    wire cmd_bad = (cyc_q != C_IDLE) || (pwr_q != P_ON) || sp == CHBD_SRSV || wd == CHBD_WRSV
        || (direct_q && sp != CHBD_TASK)
        || (sp == CHBD_ATTR && !(READY && rst_done_q));
    wire cmd_go = cmd_wr && !cmd_bad;
    wire pwr_want = ctrl_q[`CHBD_CTRL_PWR] && !CARD_DETECT_N;
    assign toff = addr_q[3:0];

    // Power sequence and mode latch
    always_ff @(posedge CLK) begin
        if (RST) begin
            pwr_q <= P_OFF;
            pcnt_q <= 17'h00000;
            direct_q <= 1'b0;
            rst_done_q <= 1'b0;
        end else if (!pwr_want) begin
            pwr_q <= P_OFF;
            pcnt_q <= 17'h00000;
            direct_q <= 1'b0;
            rst_done_q <= 1'b0;
        end else begin
            unique case (pwr_q)
                P_OFF: begin
                    pwr_q <= P_UP;
                    pcnt_q <= 17'h00000;
                end
                P_UP: begin
                    pcnt_q <= pcnt_q + 17'h00001;
                    if (pcnt_q == 17'(PWRUP_CYC - 1)) begin
                        direct_q <= ctrl_q[`CHBD_CTRL_DIRECT];
                        pwr_q <= P_RST;
                        pcnt_q <= 17'h00000;
                    end
                end
                P_RST: begin
                    pcnt_q <= pcnt_q + 17'h00001;
                    if (pcnt_q == 17'(`CHBD_RESET_CYC - 1)) begin
                        pwr_q <= P_ON;
                        rst_done_q <= 1'b1;
                    end
                end
                P_ON: begin
                    if (WR && ADDR == `CHBD_OFF_CTRL && WDATA[`CHBD_CTRL_RESET] && cyc_q == C_IDLE) begin
                        pwr_q <= P_RST;
                        pcnt_q <= 17'h00000;
                    end
                end
            endcase
        end
    end

    // Software registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_q <= `CHBD_CTRL_RST_VAL;
            addr_q <= 11'h000;
            wdata_q <= 16'h0000;
        end else if (WR) begin
            if (ADDR == `CHBD_OFF_CTRL) begin
                ctrl_q <= {WDATA[`CHBD_CTRL_IDX_LO +: 2], 1'b0, WDATA[2:0]};
            end
            if (ADDR == `CHBD_OFF_ADDR) begin
                addr_q <= WDATA[10:0];
            end
            if (ADDR == `CHBD_OFF_WDATA) begin
                wdata_q <= WDATA[15:0];
            end
        end
    end

    // Refused command flag; a new refusal wins over the clear
    always_ff @(posedge CLK) begin
        if (RST) begin
            err_q <= 1'b0;
        end else if (cmd_wr && cmd_bad) begin
            err_q <= 1'b1;
        end else if (WR && ADDR == `CHBD_OFF_STATUS && WDATA[`CHBD_ST_ERR]) begin
            err_q <= 1'b0;
        end
    end

    // Access cycle engine
    always_ff @(posedge CLK) begin
        if (RST || pwr_q != P_ON) begin
            cyc_q <= C_IDLE;
            ccnt_q <= 5'h00;
            cw_q <= CHBD_BYTE;
            cwr_q <= 1'b0;
            cio_q <= 1'b0;
            ca0_q <= 1'b0;
            cwd_q <= 16'h0000;
            drv_q <= 1'b0;
            rdata_q <= 16'h0000;
            CARD_ADDR <= 11'h000;
            ATTR_SELECT_N <= 1'b1;
            COMMAND_BLOCK_SELECT_N <= 1'b1;
            CONTROL_BLOCK_SELECT_N <= 1'b1;
        end else begin
            unique case (cyc_q)
                C_IDLE: begin
                    if (cmd_go) begin
                        cyc_q <= C_SETUP;
                        ccnt_q <= 5'h00;
                        cwr_q <= WDATA[`CHBD_CMD_WRITE];
                        cwd_q <= wdata_q;
                        cw_q <= wd;
                        ca0_q <= addr_q[0];
                        cio_q <= (sp == CHBD_TASK) && (direct_q || ctrl_q[5:4] != 2'd0);
                        drv_q <= (sp == CHBD_TASK) && (toff == `CHBD_TF_DRVADDR);
                        CARD_ADDR <= addr_q;
                        ATTR_SELECT_N <= direct_q || (sp != CHBD_ATTR && !(sp == CHBD_TASK && ctrl_q[5:4] != 2'd0));
                        if (sp == CHBD_TASK) begin
                            if (direct_q) begin
                                CARD_ADDR <= {8'h00, toff[2:0]};
                                COMMAND_BLOCK_SELECT_N <= toff[3];
                                CONTROL_BLOCK_SELECT_N <= !toff[3];
                                ca0_q <= toff[0];
                                if (toff == 4'h0 && !ctrl_q[`CHBD_CTRL_EIGHT]) begin
                                    cw_q <= CHBD_WORD;
                                end else begin
                                    cw_q <= CHBD_BYTE;
                                end
                            end else begin
                                CARD_ADDR <= map_addr(ctrl_q[5:4], toff);
                                ca0_q <= toff[0];
                            end
                        end
                    end
                end
                C_SETUP: begin
                    CARD_ADDR[0] <= lif.a0_pin;
                    ccnt_q <= ccnt_q + 5'h01;
                    if (ccnt_q == 5'(`CHBD_SETUP_CYC - 1)) begin
                        cyc_q <= C_STROBE;
                        ccnt_q <= 5'h00;
                    end
                end
                C_STROBE: begin
                    if (ccnt_q != 5'(`CHBD_STROBE_CYC - 1)) begin
                        ccnt_q <= ccnt_q + 5'h01;
                    end else if (WAIT_N) begin
                        cyc_q <= C_HOLD;
                        ccnt_q <= 5'h00;
                        if (!cwr_q) begin
                            rdata_q <= drv_q ? (lif.rdata & 16'hFF7F) : lif.rdata;
                        end
                    end
                end
                C_HOLD: begin
                    ccnt_q <= ccnt_q + 5'h01;
                    if (ccnt_q == 5'(`CHBD_HOLD_CYC - 1)) begin
                        cyc_q <= C_IDLE;
                        ATTR_SELECT_N <= 1'b1;
                        COMMAND_BLOCK_SELECT_N <= 1'b1;
                        CONTROL_BLOCK_SELECT_N <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Registered pin drive for enables, strobes and data lanes
    wire act = (cyc_q != C_IDLE) && !(cyc_q == C_HOLD && ccnt_q == 5'(`CHBD_HOLD_CYC - 1));
    wire stb = (cyc_q == C_STROBE) && !(ccnt_q == 5'(`CHBD_STROBE_CYC - 1) && WAIT_N);
    wire nxt_stb = (cyc_q == C_SETUP && ccnt_q == 5'(`CHBD_SETUP_CYC - 1)) || stb;
    always_ff @(posedge CLK) begin
        if (RST) begin
            LOW_BYTE_ENABLE_N <= 1'b1;
            HIGH_BYTE_ENABLE_N <= 1'b1;
            INTERFACE_SELECT_N <= 1'b1;
            WRITE_STROBE_N <= 1'b1;
            IO_READ_STROBE_N <= 1'b1;
            IO_WRITE_STROBE_N <= 1'b1;
            DATA_OUT <= 16'h0000;
            DATA_OE_N <= 2'b11;
            CARD_RESET <= 1'b1;
            CARD_POWER <= 1'b0;
            TRANSFER_ACKNOWLEDGE_N <= 1'b1;
        end else begin
            CARD_POWER <= pwr_want && pwr_q != P_OFF;
            CARD_RESET <= pwr_q != P_ON;
            TRANSFER_ACKNOWLEDGE_N <= 1'b1;
            LOW_BYTE_ENABLE_N <= !(act && !direct_q) || lif.ce1_n;
            HIGH_BYTE_ENABLE_N <= !(act && !direct_q) || lif.ce2_n;
            if (pwr_q == P_OFF || pwr_q == P_UP) begin
                INTERFACE_SELECT_N <= !ctrl_q[`CHBD_CTRL_DIRECT];
            end else if (direct_q) begin
                INTERFACE_SELECT_N <= 1'b0;
            end else begin
                INTERFACE_SELECT_N <= !(nxt_stb && !cio_q && !cwr_q);
            end
            WRITE_STROBE_N <= !(nxt_stb && !cio_q && cwr_q);
            IO_READ_STROBE_N <= !(nxt_stb && cio_q && !cwr_q);
            IO_WRITE_STROBE_N <= !(nxt_stb && cio_q && cwr_q);
            DATA_OUT <= lif.dout;
            DATA_OE_N <= (act && cwr_q) ? lif.doe_n : 2'b11;
        end
    end

    // Register read data, one cycle after the read strobe
    always_ff @(posedge CLK) begin
        if (RST) begin
            RDATA <= 32'h00000000;
        end else if (RD) begin
            unique case (ADDR)
                `CHBD_OFF_CTRL: RDATA <= {26'h0, ctrl_q};
                `CHBD_OFF_ADDR: RDATA <= {21'h0, addr_q};
                `CHBD_OFF_WDATA: RDATA <= {16'h0, wdata_q};
                `CHBD_OFF_STATUS: RDATA <= {19'h0, `CHBD_IRQ_LINE, 3'h0, err_q, READY,
                    pwr_q == P_ON, direct_q, cyc_q != C_IDLE};
                `CHBD_OFF_RDATA: RDATA <= {16'h0, rdata_q};
                default: RDATA <= 32'h00000000;
            endcase
        end else begin
            RDATA <= 32'h00000000;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_go;
        cmd_go;
    endsequence
    sequence s_setup;
        cyc_q == C_SETUP ##1 cyc_q == C_SETUP;
    endsequence
    property p_start;
        s_go |=> s_setup;
    endproperty
    a_start: assert property (p_start) else $error("command did not start a cycle");
    property p_wait;
        cyc_q == C_STROBE && ccnt_q == 5'(`CHBD_STROBE_CYC - 1) && !WAIT_N |=> cyc_q == C_STROBE && !act == 1'b0;
    endproperty
    a_wait: assert property (p_wait) else $error("strobe ended while wait active");
    property p_byte;
        cyc_q == C_STROBE && cw_q == CHBD_BYTE && !direct_q |=> !LOW_BYTE_ENABLE_N && HIGH_BYTE_ENABLE_N;
    endproperty
    a_byte: assert property (p_byte) else $error("byte cycle enables wrong");
    property p_bytewr;
        cyc_q == C_STROBE && cw_q == CHBD_BYTE && cwr_q |=> DATA_OE_N == 2'b10;
    endproperty
    a_bytewr: assert property (p_bytewr) else $error("byte write lanes wrong");
    property p_word;
        cyc_q == C_STROBE && cw_q == CHBD_WORD && !direct_q |=> !LOW_BYTE_ENABLE_N && !HIGH_BYTE_ENABLE_N;
    endproperty
    a_word: assert property (p_word) else $error("word cycle enables wrong");
    property p_odd;
        cyc_q == C_STROBE && cw_q == CHBD_ODD && !direct_q |=> LOW_BYTE_ENABLE_N && !HIGH_BYTE_ENABLE_N;
    endproperty
    a_odd: assert property (p_odd) else $error("odd byte enables wrong");
    property p_pwrup;
        pwr_q == P_UP && ctrl_q[`CHBD_CTRL_DIRECT] ##1 pwr_q == P_UP |-> !INTERFACE_SELECT_N;
    endproperty
    a_pwrup: assert property (p_pwrup) else $error("select not grounded in power-up");
    property p_direct;
        direct_q |-> WRITE_STROBE_N && ATTR_SELECT_N;
    endproperty
    a_direct: assert property (p_direct) else $error("memory cycle in direct mode");
    property p_remove;
        CARD_DETECT_N |=> !direct_q && pwr_q == P_OFF;
    endproperty
    a_remove: assert property (p_remove) else $error("mode kept after removal");
    property p_drv;
        cyc_q == C_HOLD && drv_q && !cwr_q |-> !rdata_q[7];
    endproperty
    a_drv: assert property (p_drv) else $error("drive address bit 7 kept");
endmodule

/* File: chbd_cfg.svh */
// Register offsets, field positions, reset values and timing counts of the card bus host
`ifndef CHBD_CFG_SVH
`define CHBD_CFG_SVH
`define CHBD_OFF_CTRL 8'h00
`define CHBD_OFF_ADDR 8'h04
`define CHBD_OFF_WDATA 8'h08
`define CHBD_OFF_CMD 8'h0C
`define CHBD_OFF_STATUS 8'h10
`define CHBD_OFF_RDATA 8'h14
`define CHBD_CTRL_PWR 0
`define CHBD_CTRL_DIRECT 1
`define CHBD_CTRL_EIGHT 2
`define CHBD_CTRL_RESET 3
`define CHBD_CTRL_IDX_LO 4
`define CHBD_CTRL_RST_VAL 6'h00
`define CHBD_CMD_WIDTH_LO 0
`define CHBD_CMD_WRITE 2
`define CHBD_CMD_SPACE_LO 3
`define CHBD_ST_ERR 4
`define CHBD_IRQ_LINE 5'h0E
`define CHBD_TF_DRVADDR 4'hF
`define CHBD_TF_ALTSTAT 4'hE
`define CHBD_PRI_CMD 11'h1F0
`define CHBD_PRI_CTL 11'h3F0
`define CHBD_SEC_CMD 11'h170
`define CHBD_SEC_CTL 11'h370
`define CHBD_CLK_NS 8
`define CHBD_SETUP_NS 30
`define CHBD_STROBE_NS 150
`define CHBD_HOLD_NS 20
`define CHBD_RESET_NS 10000
`define CHBD_PWRUP_NS 1000000
`define CHBD_SETUP_CYC ((`CHBD_SETUP_NS + `CHBD_CLK_NS - 1) / `CHBD_CLK_NS)
`define CHBD_STROBE_CYC ((`CHBD_STROBE_NS + `CHBD_CLK_NS - 1) / `CHBD_CLK_NS)
`define CHBD_HOLD_CYC ((`CHBD_HOLD_NS + `CHBD_CLK_NS - 1) / `CHBD_CLK_NS)
`define CHBD_RESET_CYC ((`CHBD_RESET_NS + `CHBD_CLK_NS - 1) / `CHBD_CLK_NS)
`define CHBD_PWRUP_CYC ((`CHBD_PWRUP_NS + `CHBD_CLK_NS - 1) / `CHBD_CLK_NS)
`endif

/* File: chbd_pkg.sv */
// Types shared by the card bus host modules
package chbd_pkg;
    typedef enum logic [1:0] {CHBD_BYTE, CHBD_WORD, CHBD_ODD, CHBD_WRSV} chbd_width_t;
    typedef enum logic [1:0] {CHBD_COMMON, CHBD_ATTR, CHBD_TASK, CHBD_SRSV} chbd_space_t;
endpackage

/* File: chbd_lane_if.sv */
// Carrier between the cycle engine and the byte lane steering
`timescale 1ns/10ps
interface chbd_lane_if;
    import chbd_pkg::*;
    chbd_width_t width;
    logic wr;
    logic a0;
    logic [15:0] wdata;
    logic [15:0] din;
    logic ce1_n;
    logic ce2_n;
    logic a0_pin;
    logic [15:0] dout;
    logic [1:0] doe_n;
    logic [15:0] rdata;
    modport eng (output width, wr, a0, wdata, din, input ce1_n, ce2_n, a0_pin, dout, doe_n, rdata);
    modport lane (input width, wr, a0, wdata, din, output ce1_n, ce2_n, a0_pin, dout, doe_n, rdata);
endinterface

/* File: chbd_lane.sv */
// Byte enable and data lane steering for byte, word and odd byte cycles
`timescale 1ns/10ps
module chbd_lane
    import chbd_pkg::*;
(
    chbd_lane_if.lane lif
);
    always_comb begin
        lif.ce1_n = 1'b1;
        lif.ce2_n = 1'b1;
        lif.a0_pin = lif.a0;
        lif.dout = 16'h0000;
        lif.doe_n = 2'b11;
        lif.rdata = 16'h0000;
        unique case (lif.width)
            CHBD_BYTE: begin
                lif.ce1_n = 1'b0;
                lif.dout = {8'h00, lif.wdata[7:0]};
                lif.doe_n = lif.wr ? 2'b10 : 2'b11;
                lif.rdata = {8'h00, lif.din[7:0]};
            end
            CHBD_WORD: begin
                lif.ce1_n = 1'b0;
                lif.ce2_n = 1'b0;
                lif.a0_pin = 1'b0;
                lif.dout = lif.wdata;
                lif.doe_n = lif.wr ? 2'b00 : 2'b11;
                lif.rdata = lif.din;
            end
            CHBD_ODD: begin
                lif.ce2_n = 1'b0;
                lif.dout = {lif.wdata[7:0], 8'h00};
                lif.doe_n = lif.wr ? 2'b01 : 2'b11;
                lif.rdata = {8'h00, lif.din[15:8]};
            end
            default: begin
                lif.ce1_n = 1'b1;
            end
        endcase
    end
endmodule

/* File: chbd_card_model.sv */
// Behavioural card that answers the host bus pins
`timescale 1ns/10ps
module chbd_card_model (
    input wire logic clk,
    input wire logic pwr,
    input wire logic crst,
    input wire logic [10:0] a,
    input wire logic attr_n,
    input wire logic ce1_n,
    input wire logic ce2_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic io_read_strobe_n_n,
    input wire logic io_write_strobe_n_n,
    input wire logic cs0_n,
    input wire logic cs1_n,
    input wire logic [15:0] dout,
    input wire logic [5:0] slow,
    input wire logic ready_en,
    output logic [15:0] din,
    output logic wait_n,
    output logic ready,
    output logic [10:0] last_addr,
    output logic direct
);
    logic [7:0] mem [0:2047];
    logic [7:0] tf [0:15];
    logic [15:0] dreg;
    logic [5:0] cnt;
    logic [8:0] low_cnt;
    logic tog = 1'b0;
    logic rst_q, we_q, io_write_strobe_n_q, io, mrd, mwr, ird, iwr, stb;
    logic [3:0] key;
    logic [7:0] flt, lo, hi;
    logic [10:0] ev, od;
    // Undriven lanes change every cycle so a stale value never passes
    assign flt = tog ? 8'h5A : 8'hA5;
    assign ev = {a[10:1], 1'b0};
    assign od = {a[10:1], 1'b1};
    assign io = direct ? !(cs0_n && cs1_n) : !attr_n;
    assign key = direct ? {!cs1_n, a[2:0]} : {a[9] | a[3], a[2:0]};
    assign mrd = pwr && !direct && !oe_n;
    assign mwr = pwr && !direct && !we_n;
    assign ird = pwr && io && !io_read_strobe_n_n;
    assign iwr = pwr && io && !io_write_strobe_n_n;
    assign stb = mrd || mwr || ird || iwr;
    assign wait_n = !(stb && cnt < slow);
    assign ready = pwr && !crst && ready_en;
    always_comb begin
        lo = flt;
        hi = flt;
        if (wait_n && ird) begin
            lo = (key == 4'h0) ? dreg[7:0] : tf[key];
            hi = (key == 4'h0) ? dreg[15:8] : flt;
            if (direct && key == 4'hF) begin
                lo[7] = flt[0];
            end
        end else if (wait_n && mrd && !attr_n) begin
            if (ready && !a[0]) begin
                lo = ~a[7:0];
            end
        end else if (wait_n && mrd) begin
            if (!ce1_n) begin
                lo = ce2_n ? mem[a] : mem[ev];
            end
            if (!ce2_n) begin
                hi = mem[od];
            end
        end
        din = {hi, lo};
    end
    always_ff @(posedge clk) begin
        tog <= !tog;
        rst_q <= crst;
        we_q <= we_n;
        io_write_strobe_n_q <= io_write_strobe_n_n;
        cnt <= stb ? cnt + 6'h01 : 6'h00;
        // Optional mode switching on the select pin is modelled too
        low_cnt <= (oe_n || !pwr) ? 9'h000 : low_cnt + {8'h00, !(&low_cnt)};
        if (!pwr) begin
            direct <= 1'b0;
        end else if (rst_q && !crst) begin
            direct <= !oe_n;
        end else if (oe_n) begin
            direct <= 1'b0;
        end else if (&low_cnt) begin
            direct <= 1'b1;
        end
        if (stb) begin
            last_addr <= a;
        end
        if (we_n && !we_q && !direct && attr_n && pwr) begin
            if (!ce1_n) begin
                mem[ce2_n ? a : ev] <= dout[7:0];
            end
            if (!ce2_n) begin
                mem[od] <= dout[15:8];
            end
        end
        if (io_write_strobe_n_n && !io_write_strobe_n_q && io && pwr) begin
            if (key == 4'h0) begin
                dreg <= dout;
            end else begin
                tf[key] <= dout[7:0];
            end
        end
    end
endmodule

/* File: chbd_host_test.sv */
// Self-checking bench of the card bus host against the card model
`timescale 1ns/10ps
`include "chbd_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module chbd_host_test;
    import chbd_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, det_n = 0, ready_en = 1;
    logic [7:0] addr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [5:0] slow = 0;
    logic [10:0] card_addr, last_addr;
    logic attr_n, ce1_n, ce2_n, oe_n, we_n, io_read_strobe_n_n, io_write_strobe_n_n, cs0_n, cs1_n;
    logic card_reset, card_power, wait_n, ready, direct;
    logic [15:0] dout, din;
    int num_errors = 0, total_checks = 0, seed = 86785, cycles = 0;
    logic [7:0] sh [0:2047];
    chbd_host #(.PWRUP_CYC(50)) dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .CARD_ADDR(card_addr), .ATTR_SELECT_N(attr_n), .LOW_BYTE_ENABLE_N(ce1_n),
        .HIGH_BYTE_ENABLE_N(ce2_n), .INTERFACE_SELECT_N(oe_n), .WRITE_STROBE_N(we_n),
        .IO_READ_STROBE_N(io_read_strobe_n_n), .IO_WRITE_STROBE_N(io_write_strobe_n_n), .COMMAND_BLOCK_SELECT_N(cs0_n),
        .CONTROL_BLOCK_SELECT_N(cs1_n), .TRANSFER_ACKNOWLEDGE_N(), .CARD_RESET(card_reset),
        .CARD_POWER(card_power), .DATA_OUT(dout), .DATA_OE_N(), .DATA_IN(din), .WAIT_N(wait_n),
        .READY(ready), .CARD_DETECT_N(det_n));
    chbd_card_model card (.clk(clk), .pwr(card_power), .crst(card_reset), .a(card_addr), .attr_n(attr_n),
        .ce1_n(ce1_n), .ce2_n(ce2_n), .oe_n(oe_n), .we_n(we_n), .io_read_strobe_n_n(io_read_strobe_n_n), .io_write_strobe_n_n(io_write_strobe_n_n),
        .cs0_n(cs0_n), .cs1_n(cs1_n), .dout(dout), .slow(slow), .ready_en(ready_en), .din(din),
        .wait_n(wait_n), .ready(ready), .last_addr(last_addr), .direct(direct));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic wrap_up();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_st(input int b, input logic v);
        logic [31:0] s;
        int i;
        i = 0;
        do begin
            reg_rd(`CHBD_OFF_STATUS, s);
            i++;
        end while (s[b] !== v && i < 4000);
        `CHK(s[b], v)
    endtask
    // One card cycle: address, data, command, then poll busy and fetch the result
    task automatic op(input logic [1:0] w, input logic wt, input logic [1:0] sp, input logic [10:0] a,
                      input logic [15:0] d, output logic [31:0] r);
        reg_wr(`CHBD_OFF_ADDR, {21'h0, a});
        reg_wr(`CHBD_OFF_WDATA, {16'h0, d});
        reg_wr(`CHBD_OFF_CMD, {27'h0, sp, wt, w});
        wait_st(0, 1'b0);
        reg_rd(`CHBD_OFF_RDATA, r);
    endtask
    task automatic sh_wr(input logic [1:0] w, input logic [10:0] a, input logic [15:0] d);
        if (w == 2'h0) begin
            sh[a] = d[7:0];
        end else if (w == 2'h1) begin
            sh[{a[10:1], 1'b0}] = d[7:0];
            sh[{a[10:1], 1'b1}] = d[15:8];
        end else begin
            sh[{a[10:1], 1'b1}] = d[7:0];
        end
    endtask
    function automatic logic [31:0] exp_rd(input logic [1:0] w, input logic [10:0] a);
        if (w == 2'h0) begin
            return {24'h0, sh[a]};
        end else if (w == 2'h1) begin
            return {16'h0, sh[{a[10:1], 1'b1}], sh[{a[10:1], 1'b0}]};
        end
        return {24'h0, sh[{a[10:1], 1'b1}]};
    endfunction
    function automatic logic [10:0] exp_io(input logic [1:0] idx, input logic [3:0] off);
        case (idx)
            2'h2: return off[3] ? 11'h3F0 + off[2:0] : 11'h1F0 + off[2:0];
            2'h3: return off[3] ? 11'h370 + off[2:0] : 11'h170 + off[2:0];
            default: return {7'h00, off};
        endcase
    endfunction
    initial begin
        logic [31:0] r, q;
        logic [15:0] d;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        reg_rd(`CHBD_OFF_STATUS, r);
        `CHK(r, 32'h0000_0E00)
        reg_rd(8'h20, r);
        `CHK(r, 32'h0)
        reg_wr(`CHBD_OFF_CTRL, 32'h1);
        wait_st(2, 1'b1);
        reg_rd(`CHBD_OFF_STATUS, r);
        `CHK(r[1], 1'b0)
        for (int i = 0; i < 32; i += 2) begin
            d = 16'($random(seed));
            op(2'h1, 1'b1, 2'h0, 11'(i), d, r);
            sh_wr(2'h1, 11'(i), d);
        end
        for (int i = 0; i < 60; i++) begin
            q = $random(seed);
            @(posedge clk) slow <= q[14] ? {2'b10, q[3:0]} : 6'h00;
            op(2'(q[7:0] % 8'd3), q[8], 2'h0, {6'h0, q[13:9]}, q[31:16], r);
            if (q[8]) begin
                sh_wr(2'(q[7:0] % 8'd3), {6'h0, q[13:9]}, q[31:16]);
            end else begin
                `CHK(r, exp_rd(2'(q[7:0] % 8'd3), {6'h0, q[13:9]}))
            end
        end
        for (int k = 0; k < 8; k++) begin
            reg_wr(`CHBD_OFF_CTRL, {26'h0, 2'(k >> 1), 4'h1});
            op(2'h0, 1'b1, 2'h2, k[0] ? 11'h00E : 11'h007, 16'h0055, r);
            `CHK(last_addr, exp_io(2'(k >> 1), k[0] ? 4'hE : 4'h7))
        end
        op(2'h3, 1'b0, 2'h0, 11'h0, 16'h0, r);
        reg_rd(`CHBD_OFF_STATUS, r);
        `CHK(r[4], 1'b1)
        reg_wr(`CHBD_OFF_STATUS, 32'h10);
        @(posedge clk) ready_en <= 1'b0;
        op(2'h0, 1'b0, 2'h1, 11'h010, 16'h0, r);
        reg_rd(`CHBD_OFF_STATUS, r);
        `CHK(r[4], 1'b1)
        reg_wr(`CHBD_OFF_STATUS, 32'h10);
        ready_en <= 1'b1;
        op(2'h0, 1'b0, 2'h1, 11'h010, 16'h0, r);
        `CHK(r, 32'h0000_00EF)
        reg_wr(`CHBD_OFF_CTRL, 32'h0);
        wait_st(2, 1'b0);
        reg_wr(`CHBD_OFF_CTRL, 32'h3);
        wait_st(2, 1'b1);
        reg_rd(`CHBD_OFF_STATUS, r);
        `CHK({r[1], direct}, 2'b11)
        op(2'h0, 1'b1, 2'h2, 11'h003, 16'h00C3, r);
        op(2'h0, 1'b0, 2'h2, 11'h003, 16'h0, r);
        `CHK(r, 32'h0000_00C3)
        op(2'h0, 1'b1, 2'h2, 11'h00F, 16'h00FF, r);
        op(2'h0, 1'b0, 2'h2, 11'h00F, 16'h0, r);
        `CHK(r, 32'h0000_007F)
        d = 16'($random(seed));
        op(2'h1, 1'b1, 2'h2, 11'h0, d, r);
        op(2'h1, 1'b0, 2'h2, 11'h0, 16'h0, r);
        `CHK(r, {16'h0, d})
        reg_wr(`CHBD_OFF_CTRL, 32'h7);
        op(2'h0, 1'b1, 2'h2, 11'h0, 16'h003C, r);
        op(2'h0, 1'b0, 2'h2, 11'h0, 16'h0, r);
        `CHK(r, 32'h0000_003C)
        reg_wr(`CHBD_OFF_CTRL, 32'hF);
        wait_st(2, 1'b1);
        reg_rd(`CHBD_OFF_STATUS, r);
        `CHK({r[1], direct}, 2'b11)
        op(2'h0, 1'b0, 2'h0, 11'h0, 16'h0, r);
        reg_rd(`CHBD_OFF_STATUS, r);
        `CHK(r[4], 1'b1)
        reg_wr(`CHBD_OFF_STATUS, 32'h10);
        @(posedge clk) det_n <= 1'b1;
        repeat (4) @(posedge clk);
        det_n <= 1'b0;
        reg_rd(`CHBD_OFF_STATUS, r);
        `CHK({r[2:1], direct}, 3'b000)
        reg_wr(`CHBD_OFF_CTRL, 32'h1);
        wait_st(2, 1'b1);
        reg_rd(`CHBD_OFF_STATUS, r);
        `CHK({r[1], direct}, 2'b00)
        wrap_up();
    end
endmodule
